// ==== core/mcsu_pkg.sv ====
// constants, field layouts and carriers of the multichannel serial global block
package mcsu_pkg;

    // ------------------------------------------------------------
    // register window
    // ------------------------------------------------------------
    localparam int WIN_BITS = 6;
    localparam int IDX_W = 4;
    localparam int REG_W = 16;
    localparam logic [IDX_W-1:0] IDX_CONFIG = 4'h0;
    localparam logic [IDX_W-1:0] IDX_TEST = 4'h1;
    localparam logic [IDX_W-1:0] IDX_ASYNC_LVL = 4'h2;
    localparam logic [IDX_W-1:0] IDX_VECTOR = 4'h3;
    localparam logic [IDX_W-1:0] IDX_SYNC_LVL = 4'h4;
    localparam logic [IDX_W-1:0] IDX_GPIO_DATA = 4'h5;
    localparam logic [IDX_W-1:0] IDX_GPIO_PIN = 4'h6;
    localparam logic [IDX_W-1:0] IDX_PIN_ASSIGN = 4'h7;
    localparam logic [IDX_W-1:0] IDX_PIN_DIR = 4'h8;
    localparam logic [IDX_W-1:0] IDX_SYNC_CTRL = 4'h9;
    localparam logic [IDX_W-1:0] IDX_ASYNCA_CTRL = 4'hA;
    localparam logic [IDX_W-1:0] IDX_ASYNCA_BAUD = 4'hB;
    localparam logic [IDX_W-1:0] IDX_ASYNCB_CTRL = 4'hC;
    localparam logic [IDX_W-1:0] IDX_ASYNCB_BAUD = 4'hD;
    localparam logic [IDX_W-1:0] IDX_STATUS = 4'hE;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CFG_STOP = 15;
    localparam int CFG_SUPV = 7;
    localparam int LVL_A_LSB = 0;
    localparam int LVL_B_LSB = 4;
    localparam int VEC_LSB = 2;
    localparam int ASG_MISO = 0;
    localparam int ASG_MOSI = 1;
    localparam int ASG_SS = 3;
    localparam int SC_EN = 15;
    localparam int SC_MASTER = 14;
    localparam int SC_SIZE16 = 13;
    localparam int SC_LSBF = 12;
    localparam int SC_CPOL = 11;
    localparam int SC_CPHA = 10;
    localparam int AC_TE = 7;
    localparam int AC_RE = 6;
    localparam int AC_NINE = 5;
    localparam int AC_PE = 4;
    localparam int AC_ODD = 3;
    localparam int AC_WAKE = 2;
    localparam int BAUD_W = 13;
    localparam int RATE_W = 8;
    localparam logic [RATE_W-1:0] RATE_MIN = 8'h02;
    localparam int NPINS = 8;

    // ------------------------------------------------------------
    // write masks and reset values
    // ------------------------------------------------------------
    function automatic logic [REG_W-1:0] mcsu_wmask(input logic [IDX_W-1:0] idx);
        unique case (idx)
            IDX_CONFIG: return 16'h808F;
            IDX_TEST: return 16'h00FF;
            IDX_ASYNC_LVL: return 16'h0077;
            IDX_VECTOR: return 16'h00FC;
            IDX_SYNC_LVL: return 16'h0007;
            IDX_GPIO_DATA: return 16'h00FF;
            IDX_PIN_ASSIGN: return 16'h000B;
            IDX_PIN_DIR: return 16'h00FF;
            IDX_SYNC_CTRL: return 16'hFCFF;
            IDX_ASYNCA_CTRL, IDX_ASYNCB_CTRL: return 16'h00FC;
            IDX_ASYNCA_BAUD, IDX_ASYNCB_BAUD: return 16'h1FFF;
            default: return 16'h0000;
        endcase
    endfunction : mcsu_wmask

    function automatic logic [REG_W-1:0] mcsu_rstval(input logic [IDX_W-1:0] idx);
        unique case (idx)
            IDX_CONFIG: return 16'h0080;
            IDX_SYNC_CTRL: return 16'h0004;
            IDX_ASYNCA_BAUD, IDX_ASYNCB_BAUD: return 16'h0004;
            default: return 16'h0000;
        endcase
    endfunction : mcsu_rstval

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic enable;
        logic master;
        logic size16;
        logic lsbFirst;
        logic cpol;
        logic cpha;
        logic [RATE_W-1:0] rate;
    } mcsu_sync_cfg_t;

    typedef struct packed {
        logic txEnable;
        logic rxEnable;
        logic nineBit;
        logic parityEn;
        logic parityOdd;
        logic wakeup;
        logic [BAUD_W-1:0] modulus;
    } mcsu_async_cfg_t;

    typedef struct packed {
        logic syncReq;
        logic asyncAReq;
        logic asyncBReq;
        logic asyncANoise;
        logic asyncBNoise;
    } mcsu_sub_status_t;

endpackage : mcsu_pkg

// ==== core/mcsu_global.sv ====
// register window, pin control and interrupt arbitration of the serial unit
`timescale 1ns/1ps
module mcsu_global #(
    parameter int ADDR_W = 24,
    parameter logic [ADDR_W-7:0] BASE = 18'h3FFF0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic moduleMapBit,
    output logic lowPower,
    output logic supervisorOnly,
    output mcsu_pkg::mcsu_sync_cfg_t syncCfg,
    output mcsu_pkg::mcsu_async_cfg_t asyncACfg,
    output mcsu_pkg::mcsu_async_cfg_t asyncBCfg,
    output logic [7:0] factoryTest,
    input wire mcsu_pkg::mcsu_sub_status_t subStatus,
    output logic [2:0] irqLevel,
    input wire logic iackStb,
    input wire logic [2:0] iackLevel,
    output logic iackValid,
    output logic [3:0] iackArb,
    output logic [7:0] iackVector,
    input wire logic [7:0] serialOut,
    output logic [7:0] serialIn,
    input wire logic [7:0] pinIn,
    output logic [7:0] pinOut,
    output logic [7:0] pinOe
);
    import mcsu_pkg::*;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rstMeta;
    logic rstN;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstN);

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic [REG_W-1:0] regFile [16];
    logic [NPINS-1:0] pinMeta;
    logic [NPINS-1:0] pinSync;
    logic busReq;
    logic inWindow;
    logic [IDX_W-1:0] idx;
    logic [REG_W-1:0] rdVal;
    logic [REG_W-1:0] laneMask;

    assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign inWindow = (wb_adr_i[ADDR_W-1:WIN_BITS] == BASE) & moduleMapBit;
    assign idx = wb_adr_i[WIN_BITS-1:2];
    assign laneMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_comb begin
        rdVal = regFile[idx] & mcsu_wmask(idx);
        if (idx == IDX_GPIO_PIN) begin
            rdVal = {8'h00, pinSync};
        end else if (idx == IDX_STATUS) begin
            rdVal = {11'h000, subStatus};
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= busReq & inWindow;
            wb_err_o <= busReq & ~inWindow;
            if (busReq & inWindow & ~wb_we_i) begin
                wb_dat_o <= {16'h0000, rdVal};
            end
        end
    end

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    function automatic logic [REG_W-1:0] merge(input logic [IDX_W-1:0] i,
                                               input logic [REG_W-1:0] old,
                                               input logic [REG_W-1:0] wd,
                                               input logic [REG_W-1:0] lanes);
        logic [REG_W-1:0] m;
        logic [REG_W-1:0] v;
        m = mcsu_wmask(i) & lanes;
        v = (old & ~m) | (wd & m);
        if (i == IDX_SYNC_CTRL && v[RATE_W-1:0] < RATE_MIN) begin
            v[RATE_W-1:0] = RATE_MIN;
        end
        return v;
    endfunction : merge

    generate
        for (genvar g = 0; g < 16; g++) begin : gRegs
            localparam logic [IDX_W-1:0] GI = IDX_W'(g);
            always_ff @(posedge clk or negedge rstN) begin
                if (!rstN) begin
                    regFile[g] <= mcsu_rstval(GI);
                end else if (busReq & inWindow & wb_we_i & (idx == GI)) begin
                    regFile[g] <= merge(GI, regFile[g], wb_dat_i[REG_W-1:0], laneMask);
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------
    logic [2:0] lvlA;
    logic [2:0] lvlB;
    logic [2:0] lvlS;
    logic [3:0] iarb;
    logic [5:0] vecBase;

    assign lowPower = regFile[IDX_CONFIG][CFG_STOP];
    assign supervisorOnly = regFile[IDX_CONFIG][CFG_SUPV];
    assign iarb = regFile[IDX_CONFIG][3:0];
    assign factoryTest = regFile[IDX_TEST][7:0];
    assign lvlA = regFile[IDX_ASYNC_LVL][LVL_A_LSB +: 3];
    assign lvlB = regFile[IDX_ASYNC_LVL][LVL_B_LSB +: 3];
    assign lvlS = regFile[IDX_SYNC_LVL][2:0];
    assign vecBase = regFile[IDX_VECTOR][VEC_LSB +: 6];

    assign syncCfg.enable = regFile[IDX_SYNC_CTRL][SC_EN];
    assign syncCfg.master = regFile[IDX_SYNC_CTRL][SC_MASTER];
    assign syncCfg.size16 = regFile[IDX_SYNC_CTRL][SC_SIZE16];
    assign syncCfg.lsbFirst = regFile[IDX_SYNC_CTRL][SC_LSBF];
    assign syncCfg.cpol = regFile[IDX_SYNC_CTRL][SC_CPOL];
    assign syncCfg.cpha = regFile[IDX_SYNC_CTRL][SC_CPHA];
    assign syncCfg.rate = regFile[IDX_SYNC_CTRL][RATE_W-1:0];

    function automatic mcsu_async_cfg_t asyncFields(input logic [REG_W-1:0] c,
                                                    input logic [REG_W-1:0] b);
        mcsu_async_cfg_t a;
        a.txEnable = c[AC_TE];
        a.rxEnable = c[AC_RE];
        a.nineBit = c[AC_NINE];
        a.parityEn = c[AC_PE];
        a.parityOdd = c[AC_ODD];
        a.wakeup = c[AC_WAKE];
        a.modulus = b[BAUD_W-1:0];
        return a;
    endfunction : asyncFields

    assign asyncACfg = asyncFields(regFile[IDX_ASYNCA_CTRL], regFile[IDX_ASYNCA_BAUD]);
    assign asyncBCfg = asyncFields(regFile[IDX_ASYNCB_CTRL], regFile[IDX_ASYNCB_BAUD]);

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    logic [NPINS-1:0] portOwned;

    assign portOwned = {asyncACfg.txEnable, asyncACfg.rxEnable,
                        asyncBCfg.txEnable, asyncBCfg.rxEnable,
                        regFile[IDX_PIN_ASSIGN][ASG_SS], syncCfg.enable,
                        regFile[IDX_PIN_ASSIGN][ASG_MOSI],
                        regFile[IDX_PIN_ASSIGN][ASG_MISO]};

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pinMeta <= 8'h00;
            pinSync <= 8'h00;
            serialIn <= 8'h00;
        end else begin
            pinMeta <= pinIn;
            pinSync <= pinMeta;
            serialIn <= pinSync;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pinOut <= 8'h00;
            pinOe <= 8'h00;
        end else begin
            for (int i = 0; i < NPINS; i++) begin
                pinOut[i] <= portOwned[i] ? serialOut[i] : regFile[IDX_GPIO_DATA][i];
            end
            pinOe <= regFile[IDX_PIN_DIR][NPINS-1:0];
        end
    end

    // ------------------------------------------------------------
    // interrupt level and acknowledge
    // ------------------------------------------------------------
    logic [2:0] effS;
    logic [2:0] effA;
    logic [2:0] effB;
    logic [2:0] maxLvl;
    logic winS;
    logic winA;
    logic winB;

    assign effS = subStatus.syncReq ? lvlS : 3'h0;
    assign effA = subStatus.asyncAReq ? lvlA : 3'h0;
    assign effB = subStatus.asyncBReq ? lvlB : 3'h0;

    always_comb begin
        maxLvl = effS;
        if (effA > maxLvl) begin
            maxLvl = effA;
        end
        if (effB > maxLvl) begin
            maxLvl = effB;
        end
    end

    assign winS = (effS != 3'h0) & (effS == iackLevel);
    assign winA = ~winS & (effA != 3'h0) & (effA == iackLevel);
    assign winB = ~winS & ~winA & (effB != 3'h0) & (effB == iackLevel);

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            irqLevel <= 3'h0;
        end else begin
            irqLevel <= maxLvl;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            iackValid <= 1'b0;
            iackArb <= 4'h0;
            iackVector <= 8'h00;
        end else begin
            iackValid <= iackStb & (winS | winA | winB) & (iarb != 4'h0);
            if (iackStb) begin
                iackArb <= iarb;
                if (winS) begin
                    iackVector <= {vecBase, 2'b10};
                end else if (winA) begin
                    iackVector <= {vecBase, 2'b00};
                end else begin
                    iackVector <= {vecBase, 2'b01};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_ACK_NEXT: assert property (busReq & inWindow |=> wb_ack_o ##1 !wb_ack_o)
        else $error("mapped request not acked for exactly one cycle");
    AST_UNMAPPED_ERR: assert property (busReq & !moduleMapBit |=> wb_err_o & !wb_ack_o)
        else $error("request with map bit clear was not refused");
    AST_NO_WRITE_UNMAPPED: assert property (busReq & wb_we_i & !moduleMapBit
                                            |=> $stable(regFile[IDX_CONFIG]))
        else $error("write changed state while map bit clear");
    AST_READ_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper data bits not zero");
    AST_WMASK: assert property ((regFile[IDX_CONFIG] & ~mcsu_wmask(IDX_CONFIG)) == 16'h0000)
        else $error("unimplemented config bit changed");
    AST_RATE_MIN: assert property (syncCfg.rate >= RATE_MIN)
        else $error("sync rate outside legal range");
    AST_VEC_CODE: assert property (iackValid |-> iackVector[1:0] != 2'b11
                                   && iackVector[7:2] == $past(vecBase))
        else $error("bad vector low bits");
    AST_SYNC_FIRST: assert property (iackStb & winS & iarb != 4'h0
                                     |=> iackValid && iackVector[1:0] == 2'b10)
        else $error("sync port lost equal-level arbitration");
    AST_LVL_ZERO: assert property (maxLvl == 3'h0 |=> irqLevel == 3'h0)
        else $error("level driven with no enabled request");
    AST_PIN_DIR: assert property (##1 pinOe == $past(regFile[IDX_PIN_DIR][7:0]))
        else $error("pin enable does not follow direction");
    AST_ACK_ERR_ONEHOT: assert property (!(wb_ack_o & wb_err_o))
        else $error("ack and err raised together");
    AST_ERR_NEXT: assert property (busReq & !inWindow |=> wb_err_o ##1 !wb_err_o)
        else $error("refused request not answered by one err pulse");
    AST_RD_DATA: assert property (busReq & inWindow & !wb_we_i & idx == IDX_GPIO_PIN
                                  |=> wb_dat_o == {24'h000000, $past(pinSync)})
        else $error("pin data read does not return synchronised pins");
    AST_IARB_ZERO: assert property (iarb == 4'h0 |=> !iackValid)
        else $error("acknowledge answered with arbitration number zero");
    AST_LVL_MATCH: assert property (iackStb & iackLevel == 3'h0 |=> !iackValid)
        else $error("level zero acknowledge was answered");
    AST_ARB_CAPTURE: assert property (iackStb |=> iackArb == $past(iarb))
        else $error("arbitration number not captured at acknowledge");
    AST_NO_STB_NO_VALID: assert property (!iackStb |=> !iackValid)
        else $error("acknowledge answer without acknowledge cycle");
    AST_IRQ_FOLLOWS: assert property (##1 irqLevel == $past(maxLvl))
        else $error("request level is not the highest requesting level");
    AST_SERIAL_IN: assert property (##1 serialIn == $past(pinSync))
        else $error("serial input does not follow synchronised pins");
    AST_PIN_OWNED: assert property (##1 pinOut ==
        $past((portOwned & serialOut) | (~portOwned & regFile[IDX_GPIO_DATA][7:0])))
        else $error("pin output does not follow its owner");

    COV_WRITE: cover property (busReq & inWindow & wb_we_i ##1 wb_ack_o);
    COV_IACK_S: cover property (iackStb & winS ##1 iackValid);
    COV_ERR: cover property (busReq & !moduleMapBit ##1 wb_err_o);
    COV_IACK_A: cover property (iackStb & winA ##1 iackValid);
    COV_IACK_B: cover property (iackStb & winB ##1 iackValid);

endmodule : mcsu_global

// ==== tb/mcsu_cpu_model.sv ====
// processor-side model: register cycles, module map bit and interrupt acknowledge
`timescale 1ns/1ps
module mcsu_cpu_model (
    input wire logic clk,
    output logic [23:0] busAdr,
    output logic [31:0] busDatW,
    output logic [3:0] busSel,
    output logic busWe,
    output logic busCyc,
    output logic busStb,
    input wire logic [31:0] busDatR,
    input wire logic busAck,
    input wire logic busErr,
    output logic mapBit,
    output logic iackStb,
    output logic [2:0] iackLevel,
    input wire logic iackValid,
    input wire logic [3:0] iackArb,
    input wire logic [7:0] iackVector
);
    initial begin
        busAdr = 24'h000000;
        busDatW = 32'h00000000;
        busSel = 4'h0;
        busWe = 1'b0;
        busCyc = 1'b0;
        busStb = 1'b0;
        mapBit = 1'b1;
        iackStb = 1'b0;
        iackLevel = 3'h0;
    end

    task automatic setMap(input logic m);
        @(posedge clk);
        mapBit <= m;
    endtask : setMap

    // st: 0 ack, 1 err, 2 no answer
    task automatic xfer(input logic we, input logic [23:0] a, input logic [15:0] wd,
                        output logic [15:0] rd, output logic [1:0] st);
        int n;
        n = 0;
        st = 2'h2;
        rd = 16'h0000;
        @(posedge clk);
        busCyc <= 1'b1;
        busStb <= 1'b1;
        busWe <= we;
        busAdr <= a;
        busSel <= 4'h3;
        busDatW <= {16'h0000, wd};
        while (n < 16) begin
            @(posedge clk);
            n++;
            if (busAck === 1'b1 || busErr === 1'b1) begin
                rd = busDatR[15:0];
                st = (busAck === 1'b1) ? 2'h0 : 2'h1;
                n = 16;
            end
        end
        busCyc <= 1'b0;
        busStb <= 1'b0;
        busWe <= 1'b0;
        @(posedge clk);
    endtask : xfer

    task automatic iack(input logic [2:0] lvl, output logic v, output logic [3:0] arb,
                        output logic [7:0] vec);
        @(posedge clk);
        iackStb <= 1'b1;
        iackLevel <= lvl;
        @(posedge clk);
        iackStb <= 1'b0;
        @(posedge clk);
        v = iackValid;
        arb = iackArb;
        vec = iackVector;
    endtask : iack
endmodule : mcsu_cpu_model

// ==== tb/mcsu_global_tb_top.sv ====
// self-checking bench of the serial unit global block
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin testsRun++; if ((gt) !== (ex)) begin \
    $display("mismatch %s expected %h seen %h", nm, ex, gt); failures++; end end
module mcsu_global_tb_top;
    import mcsu_pkg::*;
    localparam logic [23:0] WIN = 24'hFFFC00;
    localparam logic [5:0] OFS [10] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h1C,
                                        6'h20, 6'h24, 6'h28, 6'h2C};
    localparam logic [15:0] MSK [10] = '{16'h808F, 16'h00FF, 16'h0077, 16'h00FC,
                                         16'h0007, 16'h000B, 16'h00FF, 16'hFCFF, 16'h00FC, 16'h1FFF};
    logic clk, nrst, mapBit, iackStb, iackValid, ack, err, we, cyc, stb, lowPower, supv;
    logic [23:0] adr;
    logic [31:0] datW, datR;
    logic [3:0] sel, iackArb;
    logic [2:0] iackLevel, irqLevel;
    logic [7:0] iackVector, factoryTest, serialOut, serialIn, pinIn, pinOut, pinOe;
    mcsu_sync_cfg_t syncCfg;
    mcsu_async_cfg_t asyncACfg, asyncBCfg;
    mcsu_sub_status_t subStatus;
    int failures = 0;
    int testsRun = 0;

    mcsu_cpu_model cpu (.clk(clk), .busAdr(adr), .busDatW(datW), .busSel(sel), .busWe(we),
        .busCyc(cyc), .busStb(stb), .busDatR(datR), .busAck(ack), .busErr(err),
        .mapBit(mapBit), .iackStb(iackStb), .iackLevel(iackLevel), .iackValid(iackValid),
        .iackArb(iackArb), .iackVector(iackVector));
    mcsu_global DUT (.clk(clk), .nrst(nrst), .wb_adr_i(adr), .wb_dat_i(datW),
        .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(datR),
        .wb_ack_o(ack), .wb_err_o(err), .moduleMapBit(mapBit), .lowPower(lowPower),
        .supervisorOnly(supv), .syncCfg(syncCfg), .asyncACfg(asyncACfg),
        .asyncBCfg(asyncBCfg), .factoryTest(factoryTest), .subStatus(subStatus),
        .irqLevel(irqLevel), .iackStb(iackStb), .iackLevel(iackLevel),
        .iackValid(iackValid), .iackArb(iackArb), .iackVector(iackVector),
        .serialOut(serialOut), .serialIn(serialIn), .pinIn(pinIn), .pinOut(pinOut),
        .pinOe(pinOe));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic acc(input logic w, input logic [5:0] o, input logic [15:0] d,
                       output logic [15:0] r);
        logic [1:0] st;
        cpu.xfer(w, WIN | {18'h0, o}, d, r, st);
        if (st !== 2'h0) begin
            $display("mismatch bus answer expected 0 seen %h", st);
            failures++;
            tally_and_finish();
        end
    endtask : acc

    task automatic t_reset;
        logic [15:0] v;
        acc(1'b0, 6'h00, 16'h0, v); `CHK("config", 16'h0080, v)
        `CHK("supv", 1'b1, supv)
        acc(1'b0, 6'h24, 16'h0, v); `CHK("syncctl", 16'h0004, v)
        acc(1'b0, 6'h34, 16'h0, v); `CHK("baudB", 16'h0004, v)
        acc(1'b0, 6'h04, 16'h0, v); `CHK("test", 16'h0000, v)
    endtask : t_reset

    task automatic t_masks;
        logic [15:0] v;
        for (int i = 0; i < 10; i++) begin
            acc(1'b1, OFS[i], 16'hFFFF, v);
            acc(1'b0, OFS[i], 16'h0, v); `CHK("mask", MSK[i], v)
            acc(1'b1, OFS[i], 16'h0000, v);
        end
        acc(1'b0, 6'h24, 16'h0, v); `CHK("rateMin", 16'h0002, v)
        acc(1'b1, 6'h24, 16'hB502, v);
        acc(1'b0, 6'h24, 16'h0, v); `CHK("syncctl", 16'hB402, v)
        `CHK("syncCfg", 6'b101101, syncCfg[13:8])
        acc(1'b1, 6'h28, 16'h0024, v);
        `CHK("asyncA", 6'b001001, asyncACfg[18:13])
        acc(1'b1, 6'h04, 16'h125A, v); `CHK("factoryTest", 8'h5A, factoryTest)
        acc(1'b1, 6'h30, 16'hFF98, v);
        acc(1'b1, 6'h34, 16'hE123, v);
        `CHK("asyncB", {6'b100110, 13'h0123}, asyncBCfg)
        acc(1'b1, 6'h30, 16'h0000, v);
        acc(1'b1, 6'h24, 16'h0002, v);
        acc(1'b1, 6'h28, 16'h0000, v);
    endtask : t_masks

    task automatic t_map;
        logic [15:0] v;
        logic [1:0] st;
        cpu.setMap(1'b0);
        cpu.xfer(1'b1, WIN, 16'hFFFF, v, st); `CHK("mapErr", 2'h1, st)
        cpu.setMap(1'b1);
        acc(1'b0, 6'h00, 16'h0, v); `CHK("config", 16'h0000, v)
        cpu.xfer(1'b0, 24'hFFFC40, 16'h0, v, st); `CHK("outside", 2'h1, st)
        cpu.xfer(1'b0, 24'hFFFC3C, 16'h0, v, st); `CHK("last", 18'h00000, {st, v})
    endtask : t_map

    task automatic t_iack;
        logic [15:0] v;
        logic ok;
        logic [3:0] arb;
        logic [7:0] vec;
        acc(1'b1, 6'h00, 16'h8085, v); `CHK("lowPower", 1'b1, lowPower)
        acc(1'b1, 6'h00, 16'h0005, v);
        acc(1'b1, 6'h08, 16'h0055, v);
        acc(1'b1, 6'h10, 16'h0005, v);
        acc(1'b1, 6'h0C, 16'h0043, v);
        @(posedge clk);
        subStatus <= 5'b11110;
        repeat (3) @(posedge clk);
        `CHK("irqLevel", 3'h5, irqLevel)
        acc(1'b0, 6'h38, 16'h0, v); `CHK("status", 16'h001E, v)
        cpu.iack(3'h5, ok, arb, vec); `CHK("vecSync", 13'h1542, {ok, arb, vec})
        subStatus <= 5'b01100;
        cpu.iack(3'h5, ok, arb, vec); `CHK("vecA", 8'h40, vec)
        subStatus <= 5'b00100;
        cpu.iack(3'h5, ok, arb, vec); `CHK("vecB", 8'h41, vec)
        cpu.iack(3'h3, ok, arb, vec); `CHK("noMatch", 1'b0, ok)
        acc(1'b1, 6'h08, 16'h0005, v);
        repeat (3) @(posedge clk);
        `CHK("disabled", 3'h0, irqLevel)
    endtask : t_iack

    task automatic t_gpio;
        logic [15:0] v;
        acc(1'b1, 6'h20, 16'h00FF, v);
        acc(1'b1, 6'h14, 16'h00A5, v);
        repeat (3) @(posedge clk);
        `CHK("pinOut", 16'hA5FF, {pinOut, pinOe})
        pinIn <= 8'h3C;
        serialOut <= 8'h0B;
        acc(1'b1, 6'h20, 16'h0000, v);
        repeat (4) @(posedge clk);
        acc(1'b0, 6'h18, 16'h0, v); `CHK("pinData", 16'h003C, v)
        `CHK("inputs", 16'h3C00, {serialIn, pinOe})
        acc(1'b1, 6'h1C, 16'h000B, v);
        acc(1'b1, 6'h20, 16'h00FF, v);
        acc(1'b1, 6'h14, 16'h0000, v);
        repeat (3) @(posedge clk);
        `CHK("assign", 8'h0B, pinOut)
    endtask : t_gpio

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        tally_and_finish();
    end

    initial begin
        nrst = 1'b0;
        subStatus = 5'b00000;
        serialOut = 8'h00;
        pinIn = 8'h00;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_masks();
        t_map();
        t_iack();
        t_gpio();
        tally_and_finish();
    end
endmodule : mcsu_global_tb_top
